/* File: design/asp_top.sv */
// Functional notes
// - Frame is low start, data, optional parity, then high stop bits.
// - Control A bit 5 picks one or two transmitted stop bits.
// - Control B bit 0 picks one or two expected receive stop bits.
// - Bit 3 adds and checks parity; bit 4 picks odd (0) or even (1).
// - Parity setting and bit clock are shared by transmitter and receiver.
// - Baud select picks fc/13..fc/416, aux timer ticks, or fc/96.
// - With aux timer ticks selected, bit rate is tick rate over 16.
// - Idle receiver looks for low; bits voted from ticks 7, 8, 9.
// - Filter field rejects pulses under 31, 63 or 127 fc cycles.
// - Pulses over 96, 192 or 384 fc cycles always pass the filter.
// - Clearing an enable takes effect only after the current frame ends.
// - Enabling sends nothing; a frame starts only after a new buffer write.
// - Status holds six read-only flags; done and empty reset to one.
// - Holding empty flag sets when the transmit interrupt would be raised.
// - Done reads 0 while shifting and 1 after transmission ends.
// - Receive flags clear on buffer read following a status read.
// - Framing fault sets when a stop bit samples as zero.
// - Frame arriving while buffer unread sets overrun, data dropped.
// - Transmit buffer write counts only after a status read.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module asp_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // AXI4-Lite write
  input wire logic [asp_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [asp_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Serial pins and timer tick
  input wire logic rxd,
  output logic txd_q,
  input wire logic aux_timer_tick
);
  typedef enum logic [2:0] {TS_IDLE, TS_START, TS_DATA, TS_PAR, TS_STOP} asp_tx_t;
  typedef enum logic [2:0] {RS_IDLE, RS_START, RS_DATA, RS_PAR, RS_STOP} asp_rx_t;

  function automatic logic [15:0] reg_idx(input logic [asp_pkg::ADDR_W-1:0] a);
    reg_idx = a[17:2];
  endfunction

  logic [7:0] ctrl_a_q;
  logic [2:0] ctrl_b_q;
  logic [7:0] rx_buf_q, tx_buf_q;
  logic par_q, frame_q, ovr_q, full_q, done_q, empty_q;
  logic armed_q;
  wire logic wr_go = s_awvalid && s_wvalid && !s_awready && !s_bvalid;
  wire logic rd_go = s_arvalid && !s_arready && !s_rvalid;
  wire logic [15:0] wr_idx = reg_idx(s_awaddr);
  wire logic [15:0] rd_idx = reg_idx(s_araddr);
  wire logic wr_lane = wr_go && s_wstrb[0];
  wire logic wr_tx = wr_lane && wr_idx == asp_pkg::IDX_TX_HOLD;
  wire logic rd_status = rd_go && rd_idx == asp_pkg::IDX_STATUS;
  wire logic rd_rxbuf = rd_go && rd_idx == asp_pkg::IDX_RX_HOLD;
  wire logic wr_ok = wr_idx == asp_pkg::IDX_CTRL_A || wr_idx == asp_pkg::IDX_CTRL_B
                  || wr_idx == asp_pkg::IDX_TX_HOLD;
  wire logic rd_ok = rd_status || rd_rxbuf;
  wire logic [7:0] status = {par_q, frame_q, ovr_q, full_q, done_q, empty_q, 2'h0};

  // Bus handshake: both write channels taken together
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= asp_pkg::RESP_OKAY;
    end else begin
      s_awready <= wr_go;
      s_wready <= wr_go;
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? asp_pkg::RESP_OKAY : asp_pkg::RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0;
      s_rresp <= asp_pkg::RESP_OKAY;
    end else begin
      s_arready <= rd_go;
      if (rd_go) begin
        s_rvalid <= 1'b1;
        s_rdata <= {24'h0, rd_status ? status : (rd_rxbuf ? rx_buf_q : 8'h0)};
        s_rresp <= rd_ok ? asp_pkg::RESP_OKAY : asp_pkg::RESP_SLVERR;
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // Control registers are write only; A reads back as the status word, B reads zero with SLVERR
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_a_q <= asp_pkg::CA_RESET;
      ctrl_b_q <= asp_pkg::CB_RESET;
    end else if (wr_lane) begin
      if (wr_idx == asp_pkg::IDX_CTRL_A)
        ctrl_a_q <= s_wdata[7:0];
      if (wr_idx == asp_pkg::IDX_CTRL_B)
        ctrl_b_q <= s_wdata[2:0];
    end
  end

  // status read arms the next buffer access
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      armed_q <= 1'b0;
    else if (rd_status)
      armed_q <= 1'b1;
    else if (rd_rxbuf || wr_tx)
      armed_q <= 1'b0;
  end
  wire logic rx_clear = rd_rxbuf && armed_q;
  wire logic tx_accept = wr_tx && armed_q;

  // tick at sixteen times the bit rate, shared by both directions
  logic [8:0] div_cnt_q;
  logic tick_q;
  logic [2:0] aux_sync_q;
  logic [8:0] div_sel;
  wire logic [2:0] baud = ctrl_a_q[asp_pkg::CA_BAUD_LO +: 3];
  always_comb begin
    case (baud)
      3'h0: div_sel = asp_pkg::DIV_0;
      3'h1: div_sel = asp_pkg::DIV_1;
      3'h2: div_sel = asp_pkg::DIV_2;
      3'h3: div_sel = asp_pkg::DIV_3;
      3'h4: div_sel = asp_pkg::DIV_4;
      3'h5: div_sel = asp_pkg::DIV_5;
      default: div_sel = asp_pkg::DIV_7;
    endcase
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aux_sync_q <= 3'h0;
      div_cnt_q <= 9'h0;
      tick_q <= 1'b0;
    end else begin
      aux_sync_q <= {aux_sync_q[1:0], aux_timer_tick};
      if (baud == asp_pkg::BAUD_AUX) begin
        div_cnt_q <= 9'h0;
        tick_q <= aux_sync_q[1] && !aux_sync_q[2];
      end else if (div_cnt_q >= div_sel - 9'h1) begin
        div_cnt_q <= 9'h0;
        tick_q <= 1'b1;
      end else begin
        div_cnt_q <= div_cnt_q + 9'h1;
        tick_q <= 1'b0;
      end
    end
  end

  // glitch filter; a level must hold the threshold before it passes
  logic [1:0] rx_sync_q;
  logic rx_line_q;
  logic [6:0] filt_cnt_q;
  logic [6:0] filt_thr;
  wire logic [1:0] filt_mode = ctrl_b_q[asp_pkg::CB_FILT_LO +: 2];
  always_comb begin
    case (filt_mode)
      2'h1: filt_thr = asp_pkg::FILT_1;
      2'h2: filt_thr = asp_pkg::FILT_2;
      2'h3: filt_thr = asp_pkg::FILT_3;
      default: filt_thr = 7'h0;
    endcase
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_sync_q <= 2'h3;
      rx_line_q <= 1'b1;
      filt_cnt_q <= 7'h0;
    end else begin
      rx_sync_q <= {rx_sync_q[0], rxd};
      if (rx_sync_q[1] == rx_line_q) begin
        filt_cnt_q <= 7'h0;
      end else if (filt_cnt_q >= filt_thr) begin
        rx_line_q <= rx_sync_q[1];
        filt_cnt_q <= 7'h0;
      end else begin
        filt_cnt_q <= filt_cnt_q + 7'h1;
      end
    end
  end

  // Transmitter
  asp_tx_t tx_st_q;
  logic [3:0] tx_tk_q;
  logic [2:0] tx_bit_q;
  logic [7:0] tx_sh_q;
  logic tx_stop2_q, tx_par_q, tx_stop_idx_q;
  wire logic par_on = ctrl_a_q[asp_pkg::CA_PAR_ADD];
  wire logic par_even = ctrl_a_q[asp_pkg::CA_EVEN];
  // enable is looked at only between frames; only fresh data is sent
  wire logic tx_load = tx_st_q == TS_IDLE && ctrl_a_q[asp_pkg::CA_TX_EN] && !empty_q;
  wire logic tx_bit_end = tick_q && tx_tk_q == asp_pkg::TICK_LAST;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_st_q <= TS_IDLE;
      tx_tk_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_sh_q <= 8'h0;
      tx_stop2_q <= 1'b0;
      tx_par_q <= 1'b0;
      tx_stop_idx_q <= 1'b0;
      txd_q <= 1'b1;
    end else if (tx_load) begin
      tx_st_q <= TS_START;
      tx_tk_q <= 4'h0;
      tx_sh_q <= tx_buf_q;
      tx_stop2_q <= ctrl_a_q[asp_pkg::CA_TX_STOP];
      tx_par_q <= ^tx_buf_q ^ !par_even;
      txd_q <= 1'b0;
    end else if (tick_q && tx_st_q != TS_IDLE) begin
      tx_tk_q <= tx_tk_q + 4'h1;
      if (tx_bit_end) begin
        case (tx_st_q)
          TS_START: begin
            tx_st_q <= TS_DATA;
            tx_bit_q <= 3'h0;
            txd_q <= tx_sh_q[0];
          end
          TS_DATA: begin
            tx_bit_q <= tx_bit_q + 3'h1;
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            if (tx_bit_q == 3'h7) begin
              tx_st_q <= par_on ? TS_PAR : TS_STOP;
              tx_stop_idx_q <= 1'b0;
              txd_q <= par_on ? tx_par_q : 1'b1;
            end else begin
              txd_q <= tx_sh_q[1];
            end
          end
          TS_PAR: begin
            tx_st_q <= TS_STOP;
            txd_q <= 1'b1;
          end
          TS_STOP: begin
            tx_stop_idx_q <= 1'b1;
            if (tx_stop_idx_q || !tx_stop2_q)
              tx_st_q <= TS_IDLE;
          end
          default: tx_st_q <= TS_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      tx_buf_q <= 8'h0;
    else if (tx_accept)
      tx_buf_q <= s_wdata[7:0];
  end

  // empty set on load, cleared by an armed write
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      empty_q <= 1'b1;
      done_q <= 1'b1;
    end else begin
      if (tx_accept)
        empty_q <= 1'b0;
      else if (tx_load)
        empty_q <= 1'b1;
      if (tx_load)
        done_q <= 1'b0;
      else if (tx_st_q == TS_IDLE && empty_q)
        done_q <= 1'b1;
    end
  end

  // Receiver
  asp_rx_t rx_st_q;
  logic [3:0] rx_tk_q;
  logic [2:0] rx_bit_q, vote_q;
  logic [7:0] rx_sh_q;
  logic rx_par_q, rx_stop_idx_q, rx_frame_fault_q;
  wire logic rx_bit_end = tick_q && rx_tk_q == asp_pkg::TICK_LAST;
  wire logic voted = (vote_q[0] & vote_q[1]) | (vote_q[0] & vote_q[2]) | (vote_q[1] & vote_q[2]);
  wire logic rx_finish = rx_bit_end && rx_st_q == RS_STOP
                      && (rx_stop_idx_q || !ctrl_b_q[asp_pkg::CB_RX_STOP]);
  wire logic par_bad = rx_par_q != (^rx_sh_q ^ !par_even);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_st_q <= RS_IDLE;
      rx_tk_q <= 4'h0;
      rx_bit_q <= 3'h0;
      vote_q <= 3'h0;
      rx_sh_q <= 8'h0;
      rx_par_q <= 1'b0;
      rx_stop_idx_q <= 1'b0;
      rx_frame_fault_q <= 1'b0;
    end else if (tick_q) begin
      rx_tk_q <= rx_tk_q + 4'h1;
      if (rx_tk_q == asp_pkg::SAMPLE_A)
        vote_q[0] <= rx_line_q;
      if (rx_tk_q == asp_pkg::SAMPLE_B)
        vote_q[1] <= rx_line_q;
      if (rx_tk_q == asp_pkg::SAMPLE_C)
        vote_q[2] <= rx_line_q;
      case (rx_st_q)
        RS_IDLE: begin
          // enable only looked at here; overrun holds the receiver off
          rx_tk_q <= 4'h1;
          if (ctrl_a_q[asp_pkg::CA_RX_EN] && !ovr_q && !rx_line_q) begin
            rx_st_q <= RS_START;
            rx_frame_fault_q <= 1'b0;
          end
        end
        RS_START: if (rx_bit_end) begin
          rx_bit_q <= 3'h0;
          rx_st_q <= voted ? RS_IDLE : RS_DATA;
        end
        RS_DATA: if (rx_bit_end) begin
          rx_sh_q <= {voted, rx_sh_q[7:1]};
          rx_bit_q <= rx_bit_q + 3'h1;
          rx_stop_idx_q <= 1'b0;
          if (rx_bit_q == 3'h7)
            rx_st_q <= par_on ? RS_PAR : RS_STOP;
        end
        RS_PAR: if (rx_bit_end) begin
          rx_par_q <= voted;
          rx_st_q <= RS_STOP;
        end
        RS_STOP: if (rx_bit_end) begin
          // every expected stop bit is checked
          rx_stop_idx_q <= 1'b1;
          if (!voted)
            rx_frame_fault_q <= 1'b1;
          if (rx_finish)
            rx_st_q <= RS_IDLE;
        end
        default: rx_st_q <= RS_IDLE;
      endcase
    end
  end
  wire logic rx_stop_zero = rx_finish && !voted;

  // flags; hardware set wins over the clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      par_q <= 1'b0;
      frame_q <= 1'b0;
      ovr_q <= 1'b0;
      full_q <= 1'b0;
      rx_buf_q <= asp_pkg::RXBUF_RESET;
    end else if (rx_finish) begin
      if (full_q && !rx_clear) begin
        ovr_q <= 1'b1;
      end else begin
        rx_buf_q <= rx_sh_q;
        full_q <= 1'b1;
        par_q <= par_on && par_bad;
        frame_q <= rx_frame_fault_q || rx_stop_zero;
        ovr_q <= 1'b0;
      end
    end else if (rx_clear) begin
      par_q <= 1'b0;
      frame_q <= 1'b0;
      ovr_q <= 1'b0;
      full_q <= 1'b0;
    end
  end

  wire logic div_mode = baud != asp_pkg::BAUD_AUX;
  default clocking asp_cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // Armed buffer read; a frame landing the same cycle refills the buffer
  sequence s_armed_read;
    armed_q && rd_rxbuf && !rx_finish;
  endsequence

  a_start_bit_low: assert property (tx_load |=> !txd_q && tx_st_q == TS_START)
    else $error("start bit not low");
  a_stop_bit_high: assert property (tx_st_q == TS_STOP |-> txd_q)
    else $error("stop bit not high");
  a_tx_two_stop: assert property (tx_st_q == TS_STOP && tx_stop_idx_q |-> tx_stop2_q)
    else $error("extra stop bit");
  a_tick_spacing: assert property (tick_q && div_mode ##1 div_mode |-> !tick_q [*8])
    else $error("tick too soon");
  a_empty_on_load: assert property (tx_load && !tx_accept |=> empty_q)
    else $error("empty not set");
  a_done_busy: assert property (tx_st_q != TS_IDLE |-> !done_q)
    else $error("done high while busy");
  a_unarmed_write: assert property (wr_tx && !armed_q && empty_q && !tx_load |=> empty_q)
    else $error("unarmed write took");
  a_full_clear: assert property (s_armed_read |=> !full_q)
    else $error("full not cleared");
  a_overrun_keep: assert property (rx_finish && full_q && !rx_clear |=> ovr_q && $stable(rx_buf_q))
    else $error("overrun lost data");
  a_frame_fault: assert property (rx_finish && !voted && !(full_q && !rx_clear) |=> frame_q)
    else $error("frame fault missed");
endmodule // asp_top
`default_nettype wire

/* File: design/asp_pkg.sv */
package asp_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_CTRL_A = 16'h1f91;
  localparam logic [15:0] IDX_STATUS = 16'h1f91;
  localparam logic [15:0] IDX_CTRL_B = 16'h1f92;
  localparam logic [15:0] IDX_RX_HOLD = 16'h1f93;
  localparam logic [15:0] IDX_TX_HOLD = 16'h1f94;
  localparam int ADDR_W = 18;
  // line_control_a fields
  localparam int CA_TX_EN = 7;
  localparam int CA_RX_EN = 6;
  localparam int CA_TX_STOP = 5;
  localparam int CA_EVEN = 4;
  localparam int CA_PAR_ADD = 3;
  localparam int CA_BAUD_LO = 0;
  localparam logic [7:0] CA_RESET = 8'h00;
  // line_control_b fields
  localparam int CB_FILT_LO = 1;
  localparam int CB_RX_STOP = 0;
  localparam logic [2:0] CB_RESET = 3'h0;
  // line_status fields
  localparam int ST_PAR = 7;
  localparam int ST_FRAME = 6;
  localparam int ST_OVR = 5;
  localparam int ST_RXFULL = 4;
  localparam int ST_DONE = 3;
  localparam int ST_EMPTY = 2;
  localparam logic [7:0] RXBUF_RESET = 8'h00;
  // Baud select codes and divisors of fc
  localparam logic [2:0] BAUD_AUX = 3'h6;
  localparam logic [8:0] DIV_0 = 9'd13;
  localparam logic [8:0] DIV_1 = 9'd26;
  localparam logic [8:0] DIV_2 = 9'd52;
  localparam logic [8:0] DIV_3 = 9'd104;
  localparam logic [8:0] DIV_4 = 9'd208;
  localparam logic [8:0] DIV_5 = 9'd416;
  localparam logic [8:0] DIV_7 = 9'd96;
  // Ticks per bit and the majority sample points
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_A = 4'h7;
  localparam logic [3:0] SAMPLE_B = 4'h8;
  localparam logic [3:0] SAMPLE_C = 4'h9;
  // Glitch filter thresholds in fc cycles
  localparam logic [6:0] FILT_1 = 7'd31;
  localparam logic [6:0] FILT_2 = 7'd63;
  localparam logic [6:0] FILT_3 = 7'd127;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: tb/asp_serial_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_serial_peer (
  // Clock
  input wire logic clk_sys,
  // Serial lines
  input wire logic txd_q,
  output var logic rxd
);
  int bit_clk = 208;
  int frm_len = 10;
  int n_frames = 0;
  logic [11:0] cap = 12'hfff;

  initial rxd = 1'b1;

  // Mid-bit sampling; edges inside a frame are ignored while busy
  always @(negedge txd_q) begin
    cap = 12'hfff;
    repeat (bit_clk / 2) @(posedge clk_sys);
    for (int j = 0; j < frm_len; j++) begin
      cap[j] = txd_q;
      repeat (bit_clk) @(posedge clk_sys);
    end
    n_frames++;
  end

  task automatic send(input logic [11:0] bits, input int n, input int bclk);
    for (int j = 0; j <= n; j++) begin
      rxd <= (j < n) ? bits[j] : 1'b1;
      repeat (bclk) @(posedge clk_sys);
    end
  endtask

  task automatic glitch(input int wd);
    rxd <= 1'b0;
    repeat (wd) @(posedge clk_sys);
    rxd <= 1'b1;
  endtask
endmodule // asp_serial_peer
`default_nettype wire

/* File: tb/asp_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_tb_top;
  logic clk_sys, txd_q, rxd, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic resetn = 1'b0, aux_timer_tick = 1'b0, s_awvalid = 1'b0, s_wvalid = 1'b0;
  logic s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [17:0] s_awaddr = '0, s_araddr = '0;
  logic [31:0] s_wdata = '0, s_rdata, rv;
  logic [3:0] s_wstrb = '0, aux_cnt = '0;
  logic [1:0] s_bresp, s_rresp, rr;
  logic [11:0] b;
  int fails = 0, n_compared = 0, i, k, w;
  int dv[8] = '{13, 26, 52, 104, 208, 416, 8, 96};

  asp_top DUT (
    .clk_sys(clk_sys), .resetn(resetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .rxd(rxd), .txd_q(txd_q),
    .aux_timer_tick(aux_timer_tick)
  );
  asp_serial_peer u_peer (.clk_sys(clk_sys), .txd_q(txd_q), .rxd(rxd));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Timer tick rises every 8 clocks, so a bit lasts 128 clocks
  always @(posedge clk_sys) begin
    aux_cnt <= aux_cnt + 4'h1;
    aux_timer_tick <= aux_cnt[2];
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic hang();
    chk(32'h0, 32'h1);
    final_report();
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic dn;
    dn = 1'b0;
    @(posedge clk_sys);
    s_awaddr <= {idx, 2'b00};
    s_wdata <= {24'h0, d};
    s_wstrb <= 4'hf;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (int t = 0; t < 100 && !dn; t++) begin
      @(posedge clk_sys);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) begin
        rr = s_bresp;
        s_bready <= 1'b0;
        dn = 1'b1;
      end
    end
    if (!dn) hang();
  endtask

  task automatic rd(input logic [15:0] idx);
    logic dn;
    dn = 1'b0;
    @(posedge clk_sys);
    s_araddr <= {idx, 2'b00};
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (int t = 0; t < 100 && !dn; t++) begin
      @(posedge clk_sys);
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) begin
        rv = s_rdata;
        rr = s_rresp;
        s_rready <= 1'b0;
        dn = 1'b1;
      end
    end
    if (!dn) hang();
  endtask

  function automatic logic [11:0] frm(input logic [7:0] d, input logic [7:0] ca);
    logic [11:0] f;
    f = 12'hfff;
    f[0] = 1'b0;
    f[8:1] = d;
    if (ca[asp_pkg::CA_PAR_ADD]) f[9] = ca[asp_pkg::CA_EVEN] ? ^d : ~^d;
    return f;
  endfunction

  task automatic wait_tx(input logic lvl, input int lim);
    for (k = 0; k < lim && txd_q !== lvl; k++) @(posedge clk_sys);
    if (k == lim) hang();
  endtask

  task automatic tx_case(input logic [7:0] ca, input logic [7:0] d, input logic dis);
    int n0;
    wr(asp_pkg::IDX_CTRL_A, ca);
    b = frm(d, ca);
    u_peer.frm_len = 10 + ca[asp_pkg::CA_PAR_ADD] + ca[asp_pkg::CA_TX_STOP];
    n0 = u_peer.n_frames;
    rd(asp_pkg::IDX_STATUS);
    wr(asp_pkg::IDX_TX_HOLD, d);
    wait_tx(1'b0, 100);
    rd(asp_pkg::IDX_STATUS);
    chk(rv & 32'h0c, 32'h04);
    if (dis) wr(asp_pkg::IDX_CTRL_A, ca & 8'h7f);
    for (k = 0; k < 5000 && u_peer.n_frames == n0; k++) @(posedge clk_sys);
    if (k == 5000) hang();
    chk({20'h0, u_peer.cap}, {20'h0, b});
    rd(asp_pkg::IDX_STATUS);
    chk(rv & 32'h0c, 32'h0c);
  endtask

  task automatic rx_case(input logic [7:0] d, input logic [7:0] ca, input logic [2:0] cb, input int cor,
                         input logic two, input logic dis, input logic [7:0] exp);
    int n;
    wr(asp_pkg::IDX_CTRL_B, {5'h0, cb});
    wr(asp_pkg::IDX_CTRL_A, ca);
    b = frm(d, ca);
    n = 10 + ca[asp_pkg::CA_PAR_ADD] + cb[asp_pkg::CB_RX_STOP];
    if (cor == 1) b[9] = ~b[9];
    if (cor == 2) b[n - 1] = 1'b0;
    fork
      u_peer.send(b, n, 208);
      if (dis) begin
        repeat (1000) @(posedge clk_sys);
        wr(asp_pkg::IDX_CTRL_A, ca & 8'hbf);
      end
    join
    if (two) u_peer.send(frm(~d, ca), n, 208);
    rd(asp_pkg::IDX_STATUS);
    chk(rv, {24'h0, exp});
    rd(asp_pkg::IDX_RX_HOLD);
    chk(rv, {24'h0, d});
    rd(asp_pkg::IDX_STATUS);
    chk(rv, 32'h0c);
  endtask

  initial begin
    do_reset();
    wr(asp_pkg::IDX_CTRL_A, 8'h80);
    wr(asp_pkg::IDX_TX_HOLD, 8'h55);
    w = 0;
    for (k = 0; k < 300; k++) begin
      @(posedge clk_sys);
      if (txd_q !== 1'b1) w++;
    end
    chk(w, 0);
    rd(asp_pkg::IDX_STATUS);
    chk(rv, 32'h0c);
    rd(asp_pkg::IDX_RX_HOLD);
    chk(rv, 32'h0);
    rd(asp_pkg::IDX_CTRL_B);
    chk({30'h0, rr}, {30'h0, asp_pkg::RESP_SLVERR});
    wr(16'h1f95, 8'h00);
    chk({30'h0, rr}, {30'h0, asp_pkg::RESP_SLVERR});
    $display("test reset_map end");
    tx_case(8'h80, 8'h3c, 1'b0);
    tx_case(8'ha8, 8'ha5, 1'b0);
    tx_case(8'h98, 8'h01, 1'b1);
    $display("test transmit end");
    rx_case(8'h5a, 8'h40, 3'h0, 0, 1'b0, 1'b1, 8'h1c);
    rx_case(8'hc3, 8'h48, 3'h0, 0, 1'b0, 1'b0, 8'h1c);
    rx_case(8'h96, 8'h58, 3'h0, 1, 1'b0, 1'b0, 8'h9c);
    rx_case(8'h0f, 8'h40, 3'h0, 2, 1'b0, 1'b0, 8'h5c);
    rx_case(8'hf0, 8'h40, 3'h1, 2, 1'b0, 1'b0, 8'h5c);
    rx_case(8'h11, 8'h40, 3'h0, 0, 1'b1, 1'b0, 8'h3c);
    // A 120-cycle low passes modes 0 to 2 as a start (frame of ones), mode 3 rejects it
    for (i = 0; i < 4; i++) begin
      wr(asp_pkg::IDX_CTRL_B, {5'h0, i[1:0], 1'b0});
      u_peer.glitch(120);
      repeat (2500) @(posedge clk_sys);
      rd(asp_pkg::IDX_STATUS);
      chk(rv, (i == 3) ? 32'h0c : 32'h1c);
      rd(asp_pkg::IDX_RX_HOLD);
      chk(rv, 32'hff);
    end
    rx_case(8'h55, 8'h40, 3'h6, 0, 1'b0, 1'b0, 8'h1c);
    $display("test receive end");
    for (i = 0; i < 8; i++) begin
      // reset clears both enables before the baud change
      do_reset();
      wr(asp_pkg::IDX_CTRL_A, 8'h80 | i[7:0]);
      rd(asp_pkg::IDX_STATUS);
      wr(asp_pkg::IDX_TX_HOLD, 8'h02);
      wait_tx(1'b0, 200);
      wait_tx(1'b1, 20000);
      for (w = 0; w < 8000 && txd_q === 1'b1; w++) @(posedge clk_sys);
      if (w == 8000) hang();
      chk(w, 16 * dv[i]);
    end
    $display("test baud end");
    final_report();
  end
endmodule // asp_tb_top
`default_nettype wire
